//--- design/timer_pkg.sv
// Constants and carriers for the capture/compare timer.
// Assumes a 32-bit classic Wishbone bus and a 40 MHz clock.
package timer_pkg;
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_COUNT   = 8'h04;
  localparam logic [7:0] ADR_EDGE    = 8'h08;
  localparam logic [7:0] ADR_FLAGS   = 8'h0c;
  localparam logic [7:0] ADR_IRQ_EN  = 8'h10;
  localparam logic [7:0] ADR_PORT    = 8'h14;
  localparam logic [7:0] ADR_DIR     = 8'h18;
  localparam logic [7:0] ADR_OC1_MSK = 8'h1c;
  localparam logic [7:0] ADR_OC1_DAT = 8'h20;
  localparam logic [7:0] ADR_CMP_ACT = 8'h24;
  localparam logic [7:0] ADR_CAP0    = 8'h28;
  localparam logic [7:0] ADR_SHARED  = 8'h34;
  localparam logic [7:0] ADR_CMP0    = 8'h38;
  // ------------------------------------------------------------
  // Fields and reset values
  // ------------------------------------------------------------
  localparam int CTRL_CAP4 = 2;
  localparam int CTRL_DIR3 = 3;
  localparam int DIR_BIT7  = 7;
  localparam int N_CAP     = 4;
  localparam int N_CMP     = 5;
  localparam int N_FLAG    = 10;
  localparam int FLAG_CMP  = 4;
  localparam int FLAG_OVF  = 9;
  localparam logic [15:0] CMP_RESET = 16'hffff;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  // ------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    EDGE_OFF  = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_ANY  = 2'b11
  } edge_mode_t;
  typedef enum logic [1:0] {
    ACT_NONE   = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_CLEAR  = 2'b10,
    ACT_SET    = 2'b11
  } pin_act_t;
  localparam logic [3:0] PRESC_MASK1  = 4'h0;
  localparam logic [3:0] PRESC_MASK4  = 4'h3;
  localparam logic [3:0] PRESC_MASK8  = 4'h7;
  localparam logic [3:0] PRESC_MASK16 = 4'hf;
  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
  } bus_req_t;
endpackage

//--- design/timer_capture.sv
// Free-running timer with input capture, output compare and divider taps.
// Assumes a classic Wishbone master and pin levels synchronous to clk_i.
// ------------------------------------------------------------
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module timer_capture
  import timer_pkg::*;
#(
  parameter int PACC_LOG2 = 6,
  parameter int PINT_LOG2 = 13,
  parameter int WDOG_LOG2 = 15
) (
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [7:0]        pin_i,
  output logic      [7:3]        pin_o,
  output logic      [7:3]        pin_oe_o,
  output logic      [N_FLAG-1:0] irq_o,
  output logic                   pacc_tick_o,
  output logic                   pint_tick_o,
  output logic                   wdog_tick_o
);
  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  bus_req_t    req;
  logic        wr_ack;
  logic        rd_ack;
  logic [31:0] rd_data;
  assign req.adr = wb_adr_i;
  assign req.dat = wb_dat_i;
  assign req.sel = wb_sel_i;
  assign req.we  = wb_we_i;
  // Writes land on the edge the master samples ack
  assign wr_ack = wb_cyc_i & wb_stb_i & req.we & wb_ack_o;
  assign rd_ack = wb_cyc_i & wb_stb_i & ~req.we & wb_ack_o;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_cyc_i & wb_stb_i & ~wb_ack_o) begin
        wb_dat_o <= rd_data;
      end
    end
  end
  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  logic [3:0]        ctrl_reg;
  logic [7:0]        edge_reg;
  logic [N_FLAG-1:0] irq_en_reg;
  logic [7:0]        port_data_reg;
  logic              dir7_reg;
  logic [7:3]        oc1_mask_reg;
  logic [7:3]        oc1_data_reg;
  logic [7:0]        cmp_act_reg;
  logic [31:0]       wmerge;
  logic              cap4_cmp5_select;
  logic              pin3_direction;
  logic [1:0]        prescale_select;
  assign cap4_cmp5_select = ctrl_reg[CTRL_CAP4];
  assign pin3_direction   = ctrl_reg[CTRL_DIR3];
  assign prescale_select  = ctrl_reg[1:0];
  assign wmerge           = merge(32'h0000_0000, req.dat, req.sel);

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ctrl_reg      <= 4'h0;
      edge_reg      <= 8'h00;
      irq_en_reg    <= '0;
      port_data_reg <= 8'h00;
      dir7_reg      <= 1'b0;
      oc1_mask_reg  <= 5'h00;
      oc1_data_reg  <= 5'h00;
      cmp_act_reg   <= 8'h00;
    end else if (wr_ack) begin
      case (req.adr)
        ADR_CTRL:    ctrl_reg <= 4'(merge({28'h0, ctrl_reg}, req.dat, req.sel));
        ADR_EDGE:    edge_reg <= 8'(merge({24'h0, edge_reg}, req.dat, req.sel));
        ADR_IRQ_EN:  irq_en_reg <= N_FLAG'(merge({22'h0, irq_en_reg}, req.dat, req.sel));
        ADR_PORT:    port_data_reg <= 8'(merge({24'h0, port_data_reg}, req.dat, req.sel));
        ADR_DIR:     dir7_reg <= req.sel[0] ? req.dat[DIR_BIT7] : dir7_reg;
        ADR_OC1_MSK: oc1_mask_reg <= req.sel[0] ? req.dat[7:3] : oc1_mask_reg;
        ADR_OC1_DAT: oc1_data_reg <= req.sel[0] ? req.dat[7:3] : oc1_data_reg;
        ADR_CMP_ACT: cmp_act_reg <= 8'(merge({24'h0, cmp_act_reg}, req.dat, req.sel));
        default: begin
        end
      endcase
    end
  end
  // ------------------------------------------------------------
  // Prescaler, counter and divider chain
  // ------------------------------------------------------------
  logic [3:0]           presc_reg;
  logic [3:0]           presc_mask;
  logic                 tick;
  logic [15:0]          count_reg;
  logic                 step_reg;
  logic [WDOG_LOG2-1:0] chain_reg;

  always_comb begin
    case (prescale_select)
      2'b00:   presc_mask = PRESC_MASK1;
      2'b01:   presc_mask = PRESC_MASK4;
      2'b10:   presc_mask = PRESC_MASK8;
      default: presc_mask = PRESC_MASK16;
    endcase
  end
  assign tick = (presc_reg & presc_mask) == presc_mask;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      presc_reg <= 4'h0;
    end else begin
      presc_reg <= presc_reg + 4'h1;
    end
  end

  // No bus path writes the counter; only reset and the prescaler tick change it
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      count_reg <= 16'h0000;
      step_reg  <= 1'b0;
    end else begin
      step_reg <= tick;
      if (tick) begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      chain_reg   <= '0;
      pacc_tick_o <= 1'b0;
      pint_tick_o <= 1'b0;
      wdog_tick_o <= 1'b0;
    end else begin
      chain_reg   <= chain_reg + 1'b1;
      pacc_tick_o <= &chain_reg[PACC_LOG2-1:0];
      pint_tick_o <= &chain_reg[PINT_LOG2-1:0];
      wdog_tick_o <= &chain_reg;
    end
  end
  // ------------------------------------------------------------
  // Input capture
  // ------------------------------------------------------------
  logic [N_CAP-1:0] lvl;
  logic [N_CAP-1:0] sync1_reg;
  logic [N_CAP-1:0] sync2_reg;
  logic [N_CAP-1:0] sync3_reg;
  logic [N_CAP-1:0] hit;
  logic [N_CAP-1:0] latch_now;
  logic [N_CAP-1:0] pend_reg;
  logic [N_CAP-1:0] hold_reg;
  logic [15:0]      cap_reg [0:2];
  logic [15:0]      shared_reg;
  // Pin three loops back its own drive so software edges capture too
  assign lvl = {pin_oe_o[3] ? pin_o[3] : pin_i[3], pin_i[2:0]};

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      pend_reg  <= '0;
      hold_reg  <= '0;
    end else begin
      sync1_reg <= lvl;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pend_reg  <= (pend_reg | hit) & hold_reg;
      for (int i = 0; i < N_CAP; i++) begin
        hold_reg[i] <= rd_ack & req.sel[1] & (req.adr == ADR_CAP0 + 8'(4 * i));
      end
    end
  end

  always_comb begin
    for (int i = 0; i < N_CAP; i++) begin
      case (edge_mode_t'(edge_reg[2*i +: 2]))
        EDGE_RISE: hit[i] = sync2_reg[i] & ~sync3_reg[i];
        EDGE_FALL: hit[i] = ~sync2_reg[i] & sync3_reg[i];
        EDGE_ANY:  hit[i] = sync2_reg[i] ^ sync3_reg[i];
        default:   hit[i] = 1'b0;
      endcase
    end
    hit[3] = hit[3] & cap4_cmp5_select;
  end
  assign latch_now = (pend_reg | hit) & ~hold_reg;

  // Latch registers have no reset; the count is stable across the cycle
  for (genvar g = 0; g < 3; g++) begin : g_cap
    always_ff @(posedge clk_i) begin
      if (latch_now[g]) begin
        cap_reg[g] <= count_reg;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      shared_reg <= CMP_RESET;
    end else if (latch_now[3]) begin
      shared_reg <= count_reg;
    end else if (wr_ack && req.adr == ADR_SHARED && !cap4_cmp5_select) begin
      shared_reg <= 16'(merge({16'h0, shared_reg}, req.dat, req.sel));
    end
  end
  // ------------------------------------------------------------
  // Output compare
  // ------------------------------------------------------------
  logic [15:0]      cmp_reg [0:3];
  logic [15:0]      cmp_val [0:4];
  logic [N_CMP-1:0] match;
  logic [7:3]       oc_level_reg;
  logic [7:3]       owned;
  for (genvar g = 0; g < 4; g++) begin : g_cmp
    always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
        cmp_reg[g] <= CMP_RESET;
      end else if (wr_ack && req.adr == ADR_CMP0 + 8'(4 * g)) begin
        cmp_reg[g] <= 16'(merge({16'h0, cmp_reg[g]}, req.dat, req.sel));
      end
    end
    assign cmp_val[g] = cmp_reg[g];
  end
  assign cmp_val[4] = shared_reg;

  always_comb begin
    for (int j = 0; j < N_CMP; j++) begin
      match[j] = step_reg & (count_reg == cmp_val[j]);
    end
    match[4] = match[4] & ~cap4_cmp5_select;
  end

  // Pins 6..3 follow compares 2..5; action field k-3 serves pin k
  always_comb begin
    owned = oc1_mask_reg;
    for (int k = 4; k < 7; k++) begin
      owned[k] = oc1_mask_reg[k] | (cmp_act_reg[2*(k-3) +: 2] != ACT_NONE);
    end
    owned[3] = ~cap4_cmp5_select & (oc1_mask_reg[3] | (cmp_act_reg[1:0] != ACT_NONE));
  end

  // First compare wins over the per-pin compare on a shared pin
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      oc_level_reg <= 5'h00;
    end else begin
      for (int k = 3; k < 7; k++) begin
        if (match[7-k]) begin
          case (pin_act_t'(cmp_act_reg[2*(k-3) +: 2]))
            ACT_TOGGLE: oc_level_reg[k] <= ~oc_level_reg[k];
            ACT_CLEAR:  oc_level_reg[k] <= 1'b0;
            ACT_SET:    oc_level_reg[k] <= 1'b1;
            default:    oc_level_reg[k] <= oc_level_reg[k];
          endcase
        end
      end
      for (int k = 3; k < 8; k++) begin
        if (match[0] && oc1_mask_reg[k]) begin
          oc_level_reg[k] <= oc1_data_reg[k];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pin_o    <= 5'h00;
      pin_oe_o <= 5'h00;
    end else begin
      for (int k = 3; k < 8; k++) begin
        pin_o[k] <= owned[k] ? oc_level_reg[k] : port_data_reg[k];
      end
      pin_oe_o[7]   <= dir7_reg | oc1_mask_reg[7];
      pin_oe_o[6:4] <= 3'b111;
      pin_oe_o[3]   <= pin3_direction | owned[3];
    end
  end
  // ------------------------------------------------------------
  // Flags and interrupt requests
  // ------------------------------------------------------------
  logic [N_FLAG-1:0] flag_reg;
  logic [N_FLAG-1:0] flag_set;
  logic [N_FLAG-1:0] flag_clr;
  assign flag_set = {tick && count_reg == COUNT_MAX, match, latch_now};
  assign flag_clr = (wr_ack && req.adr == ADR_FLAGS) ? wmerge[N_FLAG-1:0] : '0;

  // A set in the clearing cycle survives
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      flag_reg <= '0;
      irq_o    <= '0;
    end else begin
      flag_reg <= (flag_reg & ~flag_clr) | flag_set;
      irq_o    <= flag_reg & irq_en_reg;
    end
  end
  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  always_comb begin
    rd_data = 32'h0000_0000;
    case (req.adr)
      ADR_CTRL:    rd_data[3:0] = ctrl_reg;
      ADR_COUNT:   rd_data[15:0] = count_reg;
      ADR_EDGE:    rd_data[7:0] = edge_reg;
      ADR_FLAGS:   rd_data[N_FLAG-1:0] = flag_reg;
      ADR_IRQ_EN:  rd_data[N_FLAG-1:0] = irq_en_reg;
      ADR_PORT:    rd_data[7:0] = pin_i;
      ADR_DIR:     rd_data[DIR_BIT7] = dir7_reg;
      ADR_OC1_MSK: rd_data[7:3] = oc1_mask_reg;
      ADR_OC1_DAT: rd_data[7:3] = oc1_data_reg;
      ADR_CMP_ACT: rd_data[7:0] = cmp_act_reg;
      ADR_CAP0:    rd_data[15:0] = cap_reg[0];
      8'h2c:       rd_data[15:0] = cap_reg[1];
      8'h30:       rd_data[15:0] = cap_reg[2];
      ADR_SHARED:  rd_data[15:0] = shared_reg;
      8'h38:       rd_data[15:0] = cmp_reg[0];
      8'h3c:       rd_data[15:0] = cmp_reg[1];
      8'h40:       rd_data[15:0] = cmp_reg[2];
      8'h44:       rd_data[15:0] = cmp_reg[3];
      default:     rd_data = 32'h0000_0000;
    endcase
  end
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence seq_wrap;
    tick && count_reg == COUNT_MAX;
  endsequence
  sequence seq_held_edge;
    hold_reg[0] && hit[0];
  endsequence

  // Tick runs during reset, so the release edge must not count as a step
  chk_count_step: assert property (@(posedge clk_i) disable iff (!nrst_i)
    nrst_i && tick && count_reg != COUNT_MAX |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("counter did not advance by one on tick");
  chk_count_still: assert property (@(posedge clk_i) disable iff (!nrst_i)
    nrst_i && !tick |=> $stable(count_reg))
    else $error("counter moved without a prescaler tick");
  chk_wrap_flag: assert property (@(posedge clk_i) disable iff (!nrst_i)
    seq_wrap |=> count_reg == 16'h0000 && flag_reg[FLAG_OVF])
    else $error("wrap did not clear count and set overflow");
  chk_reset_state: assert property (@(posedge clk_i)
    !nrst_i |=> count_reg == 16'h0000 && !cap4_cmp5_select && !pin3_direction)
    else $error("reset state wrong");
  chk_capture_value: assert property (@(posedge clk_i) disable iff (!nrst_i)
    latch_now[0] |=> cap_reg[0] == $past(count_reg))
    else $error("capture latched wrong count");
  chk_same_count: assert property (@(posedge clk_i) disable iff (!nrst_i)
    latch_now[1] && latch_now[2] |=> cap_reg[1] == cap_reg[2])
    else $error("simultaneous captures differ");
  chk_held_capture: assert property (@(posedge clk_i) disable iff (!nrst_i)
    seq_held_edge |-> !latch_now[0] ##1 latch_now[0])
    else $error("held capture lost or not delayed");
  chk_edge_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
    edge_reg[1:0] == EDGE_OFF |-> !hit[0])
    else $error("disabled channel saw an edge");
  chk_shared_ignore: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cap4_cmp5_select && wr_ack && req.adr == ADR_SHARED && !latch_now[3] |=> $stable(shared_reg))
    else $error("shared register written in capture mode");
  chk_port_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
    owned[6] |=> pin_o[6] == $past(oc_level_reg[6]))
    else $error("port data drove a compare pin");
  chk_wdog_gap: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wdog_tick_o |=> !wdog_tick_o [*8])
    else $error("watchdog tap too frequent");
endmodule

//--- test/pin_source.sv
// Model of the external signal sources that drive the timer's pins.
// Assumes the bench calls set_ext; the timer may drive pins seven to three itself.
`timescale 1ns/1ps
module pin_source (
  input  wire logic       clk_i,
  input  wire logic [7:3] pin_o_i,
  input  wire logic [7:3] pin_oe_i,
  output logic      [7:0] pin_lvl_o
);
  // ----------------------------------------
  // Source levels
  // ----------------------------------------
  logic [7:0] ext_reg;
  initial ext_reg = 8'h00;
  // A new level lands just after a rising edge, as a real source seen by the timer would
  task automatic set_ext(input logic [7:0] v);
    @(posedge clk_i);
    ext_reg <= v;
  endtask
  // ----------------------------------------
  // Pin resolution
  // ----------------------------------------
  // Where the timer enables its driver, its level wins over the source
  always_comb begin
    pin_lvl_o = ext_reg;
    for (int i = 3; i < 8; i++) begin
      if (pin_oe_i[i]) begin
        pin_lvl_o[i] = pin_o_i[i];
      end
    end
  end
endmodule

//--- test/test_timer_capture.sv
// Self-checking bench for the capture/compare timer.
// Assumes the timer package and the pin source model are compiled first.
`timescale 1ns/1ps
module test_timer_capture;
  import timer_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic              clk_i;
  logic              nrst_i;
  logic              cyc;
  bus_req_t          req;
  logic [31:0]       dat_o;
  logic              ack;
  logic [7:0]        pin_lvl;
  logic [7:3]        pin_o;
  logic [7:3]        pin_oe;
  logic [N_FLAG-1:0] irq;
  logic [2:0]        tk;
  int                failures;
  int                tests_run;
  // Short tap lengths keep the divider checks brief
  timer_capture #(.PACC_LOG2(4), .PINT_LOG2(5), .WDOG_LOG2(6)) dut_u (
    .clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(req.we),
    .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_sel_i(req.sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe_o(pin_oe), .irq_o(irq),
    .pacc_tick_o(tk[0]), .pint_tick_o(tk[1]), .wdog_tick_o(tk[2]));
  pin_source src_u (.clk_i(clk_i), .pin_o_i(pin_o), .pin_oe_i(pin_oe), .pin_lvl_o(pin_lvl));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // Every access costs three edges, so gaps between samples stay exact
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{adr: a, dat: d, sel: 4'hf, we: w};
    cyc <= 1'b1;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20) check(1'b0, 1'b1, "no ack");
    q = dat_o;
    cyc <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic end_of_test();
    $display("Counts: %0d compared, %0d mismatched", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    rd(ADR_CTRL, q);
    check(q, 32'h0, "ctrl reset");
    check({27'h0, pin_oe}, 32'h0e, "drivers after reset");
    rd(ADR_SHARED, q);
    check(q, {16'h0, CMP_RESET}, "shared reset");
    rd(8'hfc, q);
    check(q, 32'h0, "unmapped");
    $display("done: reset");
  endtask
  task automatic t_prescale();
    logic [31:0] a;
    logic [31:0] b;
    logic [15:0] d;
    for (int s = 0; s < 4; s++) begin
      wr(ADR_CTRL, 32'(s));
      rd(ADR_COUNT, a);
      wr(ADR_COUNT, 32'h0);
      repeat (58) @(posedge clk_i);
      rd(ADR_COUNT, b);
      d = b[15:0] - a[15:0];
      check({16'h0, d}, (s == 0) ? 32'd64 : 32'(64 >> (s + 1)), "count step");
    end
    $display("done: prescale");
  endtask
  task automatic t_overflow();
    logic [31:0] q;
    int n;
    wr(ADR_CTRL, 32'h0);
    wr(ADR_FLAGS, 32'h200);
    wr(ADR_IRQ_EN, 32'h200);
    n = 0;
    while (irq[FLAG_OVF] !== 1'b1 && n < 70000) begin
      @(posedge clk_i);
      n++;
    end
    check({31'h0, irq[FLAG_OVF]}, 32'h1, "overflow irq");
    rd(ADR_COUNT, q);
    check({31'h0, q[15:0] < 16'h0010}, 32'h1, "count after wrap");
    wr(ADR_FLAGS, 32'h200);
    rd(ADR_FLAGS, q);
    check({31'h0, q[FLAG_OVF]}, 32'h0, "overflow cleared");
    $display("done: overflow");
  endtask
  task automatic t_capture();
    logic [31:0] v;
    logic [31:0] c;
    logic [31:0] q;
    wr(ADR_EDGE, 32'h39);
    for (int k = 0; k < 2; k++) begin
      wr(ADR_FLAGS, 32'h3ff);
      rd(ADR_COUNT, v);
      src_u.set_ext((k == 0) ? 8'h07 : 8'h00);
      repeat (6) @(posedge clk_i);
      rd(ADR_CAP0 + 8'(4 * k), c);
      check({16'h0, c[15:0]}, {16'h0, v[15:0] + 16'h5}, "capture value");
      rd(ADR_CAP0 + 8'h08, q);
      check({16'h0, q[15:0]}, {16'h0, c[15:0]}, "same cycle capture");
      rd(ADR_FLAGS, q);
      check({28'h0, q[3:0]}, (k == 0) ? 32'h5 : 32'h6, "edge select");
      rd(ADR_PORT, q);
      check({28'h0, q[3:0]}, (k == 0) ? 32'h7 : 32'h0, "port levels");
    end
    // Edge lands in the cycle after a capture read, so the latch slips one cycle
    wr(ADR_FLAGS, 32'h3ff);
    rd(ADR_COUNT, v);
    fork
      src_u.set_ext(8'h01);
      rd(ADR_CAP0, q);
    join
    repeat (4) @(posedge clk_i);
    rd(ADR_CAP0, c);
    check({16'h0, c[15:0]}, {16'h0, v[15:0] + 16'h6}, "held capture delayed");
    $display("done: capture");
  endtask
  task automatic t_first_cmp();
    logic [31:0] v;
    logic [31:0] q;
    wr(ADR_OC1_MSK, 32'hf8);
    wr(ADR_OC1_DAT, 32'ha8);
    rd(ADR_COUNT, v);
    wr(ADR_CMP0, {16'h0, v[15:0] + 16'd40});
    repeat (60) @(posedge clk_i);
    check({27'h0, pin_o}, 32'h15, "first compare pins");
    check({27'h0, pin_oe}, 32'h1f, "compare drivers on");
    wr(ADR_PORT, 32'hff);
    repeat (4) @(posedge clk_i);
    check({28'h0, pin_o[7:4]}, 32'ha, "port write blocked");
    wr(ADR_OC1_MSK, 32'h00);
    wr(ADR_CMP_ACT, 32'hc0);
    wr(ADR_FLAGS, 32'h3ff);
    rd(ADR_COUNT, v);
    wr(ADR_CMP0 + 8'h04, {16'h0, v[15:0] + 16'd40});
    repeat (60) @(posedge clk_i);
    check({31'h0, pin_o[6]}, 32'h1, "second compare sets pin");
    rd(ADR_FLAGS, q);
    check({31'h0, q[FLAG_CMP + 1]}, 32'h1, "second compare flag");
    $display("done: first compare");
  endtask
  task automatic t_shared();
    logic [31:0] q;
    wr(ADR_PORT, 32'h00);
    wr(ADR_SHARED, 32'h1234);
    rd(ADR_SHARED, q);
    check(q, 32'h1234, "shared as compare");
    wr(ADR_CTRL, 32'h4);
    wr(ADR_SHARED, 32'h5678);
    rd(ADR_SHARED, q);
    check(q, 32'h1234, "shared write ignored");
    wr(ADR_EDGE, 32'h40);
    wr(ADR_CTRL, 32'hc);
    wr(ADR_FLAGS, 32'h3ff);
    wr(ADR_PORT, 32'h08);
    repeat (6) @(posedge clk_i);
    rd(ADR_FLAGS, q);
    check({31'h0, q[3]}, 32'h1, "own drive captures");
    $display("done: shared");
  endtask
  task automatic t_ticks();
    int n;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      while (tk[k] !== 1'b1 && n < 200) begin
        @(posedge clk_i);
        n++;
      end
      n = 0;
      @(posedge clk_i);
      while (tk[k] !== 1'b1 && n < 200) begin
        @(posedge clk_i);
        n++;
      end
      check(32'(n + 1), 32'(16 << k), "tap period");
    end
    $display("done: ticks");
  endtask
  task automatic t_keep();
    logic [31:0] a;
    logic [31:0] b;
    rd(ADR_CAP0, a);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(ADR_CAP0, b);
    check(b, a, "capture kept");
    $display("done: keep");
  endtask
  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // About 70k cycles are needed; the overflow wait dominates
  initial begin
    #2375000;
    failures++;
    end_of_test();
  end
  initial begin
    failures = 0;
    tests_run = 0;
    nrst_i = 1'b0;
    cyc = 1'b0;
    req = '0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_prescale();
    t_overflow();
    t_capture();
    t_first_cmp();
    t_shared();
    t_ticks();
    t_keep();
    end_of_test();
  end
endmodule
